// ===== hdl/tws_consts.vh
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TWS_OFS_OWN 8'h20
`define TWS_OFS_CTL 8'h21
`define TWS_OFS_STAT 8'h22
`define TWS_OFS_DATA 8'h23

// ----------------------------------------
// link_control_reg fields
// ----------------------------------------
`define TWS_CTL_EN 7
`define TWS_CTL_TX 4
`define TWS_CTL_ACK 3

// ----------------------------------------
// link_status_reg fields
// ----------------------------------------
`define TWS_ST_DONE 7
`define TWS_ST_HIT 6
`define TWS_ST_BUSY 5
`define TWS_ST_SRW 2
`define TWS_ST_ACK_RECEIVED 0

// ----------------------------------------
// own_address_reg field and misc values
// ----------------------------------------
`define TWS_OWN_MSB 7
`define TWS_OWN_LSB 1
`define TWS_ZERO_BYTE 8'h00
`define TWS_LAST_BIT 3'h7
`define TWS_IRQ_VECTOR 12'h010

`endif

// ===== hdl/tws_slave.v
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "tws_consts.vh"

// Summary of operation
// - bus pins only pulled low or released
// - slave only, transmit or receive
// - every data byte passes data register
// - link_enable gates all port activity
// - transmit_select picks data direction
// - ack_to_send driven at ninth clock
// - byte_done low during data shift, high after
// - address hit sets flag and request
// - enabled request calls vector 10H
// - control write or mismatch clears hit
// - START sets busy, STOP clears it
// - eighth address bit stored as read request
// - master acknowledge captured in ack_received
// - transmitter releases data on no acknowledge
// - own address in bits seven to one
// - seven address bits shifted msb first
// - one interrupt for hit and byte
// - clock held low until data access
// - data bytes shifted msb first
// - matched address acknowledged low at ninth
module tws_slave (
    input wire i_mclk,
    input wire i_rst_n,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output reg [7:0] o_rdata,
    input wire i_scl,
    output reg o_scl_out,
    output reg o_scl_oe_n,
    input wire i_sda,
    output reg o_sda_out,
    output reg o_sda_oe_n,
    input wire i_irq_enable,
    input wire i_stack_full,
    output reg o_irq_request,
    output reg o_call,
    output reg [11:0] o_call_vector
);
    // ----------------------------------------
    // states
    // ----------------------------------------
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_ADDR = 3'h1;
    localparam [2:0] S_ACKD = 3'h2;
    localparam [2:0] S_ACKE = 3'h3;
    localparam [2:0] S_HOLD = 3'h4;
    localparam [2:0] S_REL = 3'h5;
    localparam [2:0] S_DATA = 3'h6;
    localparam [2:0] S_IGN = 3'h7;

    function sel;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            sel = (addr == ofs);
        end
    endfunction

    // ----------------------------------------
    // registers and link state
    // ----------------------------------------
    reg [6:0] own_addr;
    reg link_enable;
    reg transmit_select;
    reg ack_to_send;
    reg byte_done_flag;
    reg address_hit_flag;
    reg bus_occupied_flag;
    reg master_read_request;
    reg ack_received;
    reg [7:0] data_reg;
    reg [7:0] shifter;
    reg [2:0] bit_cnt;
    reg [2:0] state;
    reg release_req;
    reg xmit;
    reg ack_val;
    reg scl_d;
    reg sda_d;
    reg [7:0] next_rdata;
    reg [7:0] ctl_view;
    reg [7:0] stat_view;

    wire [1:0] pins_sync;
    wire scl_s = pins_sync[1];
    wire sda_s = pins_sync[0];

    wire wr_own = i_wr & sel(i_addr, `TWS_OFS_OWN);
    wire wr_ctl = i_wr & sel(i_addr, `TWS_OFS_CTL);
    wire wr_dat = i_wr & sel(i_addr, `TWS_OFS_DATA);
    wire rd_dat = i_rd & sel(i_addr, `TWS_OFS_DATA);

    wire scl_rise = scl_s & ~scl_d;
    wire scl_fall = ~scl_s & scl_d;
    wire start_seen = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_seen = scl_s & scl_d & ~sda_d & sda_s;
    wire [7:0] shift_in = {shifter[6:0], sda_s};
    wire last_bit = (bit_cnt == `TWS_LAST_BIT);

    // ----------------------------------------
    // pin sampling
    // ----------------------------------------
    tws_sync #(
        .W(2),
        .RST(2'h3)
    ) u_sync (
        .i_clk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_d({i_scl, i_sda}),
        .o_q(pins_sync)
    );

    // ----------------------------------------
    // read view
    // ----------------------------------------
    always @* begin
        ctl_view = `TWS_ZERO_BYTE;
        ctl_view[`TWS_CTL_EN] = link_enable;
        ctl_view[`TWS_CTL_TX] = transmit_select;
        ctl_view[`TWS_CTL_ACK] = ack_to_send;
        stat_view = `TWS_ZERO_BYTE;
        stat_view[`TWS_ST_DONE] = byte_done_flag;
        stat_view[`TWS_ST_HIT] = address_hit_flag;
        stat_view[`TWS_ST_BUSY] = bus_occupied_flag;
        stat_view[`TWS_ST_SRW] = master_read_request;
        stat_view[`TWS_ST_ACK_RECEIVED] = ack_received;
        next_rdata = `TWS_ZERO_BYTE;
        if (sel(i_addr, `TWS_OFS_OWN)) begin
            next_rdata[`TWS_OWN_MSB:`TWS_OWN_LSB] = own_addr;
        end else if (sel(i_addr, `TWS_OFS_CTL)) begin
            next_rdata = ctl_view;
        end else if (sel(i_addr, `TWS_OFS_STAT)) begin
            next_rdata = stat_view;
        end else if (sel(i_addr, `TWS_OFS_DATA)) begin
            next_rdata = data_reg;
        end
    end

    // ----------------------------------------
    // main sequencer
    // ----------------------------------------
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rdata <= `TWS_ZERO_BYTE;
            o_scl_out <= 1'b0;
            o_scl_oe_n <= 1'b1;
            o_sda_out <= 1'b0;
            o_sda_oe_n <= 1'b1;
            o_irq_request <= 1'b0;
            o_call <= 1'b0;
            o_call_vector <= `TWS_IRQ_VECTOR;
            own_addr <= 7'h00;
            link_enable <= 1'b0;
            transmit_select <= 1'b0;
            ack_to_send <= 1'b0;
            byte_done_flag <= 1'b0;
            address_hit_flag <= 1'b0;
            bus_occupied_flag <= 1'b0;
            master_read_request <= 1'b0;
            ack_received <= 1'b0;
            data_reg <= `TWS_ZERO_BYTE;
            shifter <= `TWS_ZERO_BYTE;
            bit_cnt <= 3'h0;
            state <= S_IDLE;
            release_req <= 1'b0;
            xmit <= 1'b0;
            ack_val <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            // pins are only ever pulled low; level comes from pull-ups
            o_scl_out <= 1'b0;
            o_sda_out <= 1'b0;
            o_call_vector <= `TWS_IRQ_VECTOR;
            o_call <= 1'b0;
            scl_d <= scl_s;
            sda_d <= sda_s;
            o_rdata <= i_rd ? next_rdata : `TWS_ZERO_BYTE;
            if (wr_ctl) begin
                address_hit_flag <= 1'b0;
            end
            // the call consumes the request; a new event below re-arms it
            if (o_irq_request & i_irq_enable & ~i_stack_full) begin
                o_call <= 1'b1;
                o_irq_request <= 1'b0;
            end
            if (!link_enable) begin
                state <= S_IDLE;
                o_scl_oe_n <= 1'b1;
                o_sda_oe_n <= 1'b1;
                bus_occupied_flag <= 1'b0;
            end else if (start_seen) begin
                bus_occupied_flag <= 1'b1;
                state <= S_ADDR;
                bit_cnt <= 3'h0;
                xmit <= 1'b0;
                o_scl_oe_n <= 1'b1;
                o_sda_oe_n <= 1'b1;
            end else if (stop_seen) begin
                bus_occupied_flag <= 1'b0;
                state <= S_IDLE;
                o_scl_oe_n <= 1'b1;
                o_sda_oe_n <= 1'b1;
            end else begin
                case (state)
                    S_ADDR: begin
                        if (scl_rise) begin
                            shifter <= shift_in;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (last_bit) begin
                                if (shifter[6:0] == own_addr) begin
                                    address_hit_flag <= 1'b1;
                                    o_irq_request <= 1'b1;
                                    master_read_request <= sda_s;
                                    byte_done_flag <= 1'b1;
                                    release_req <= 1'b0;
                                    ack_val <= 1'b0;
                                    state <= S_ACKD;
                                end else begin
                                    address_hit_flag <= 1'b0;
                                    state <= S_IGN;
                                end
                            end
                        end
                    end
                    S_ACKD: begin
                        if (scl_fall) begin
                            o_sda_oe_n <= ack_val;
                            state <= S_ACKE;
                        end
                    end
                    S_ACKE: begin
                        if (scl_rise && xmit) begin
                            ack_received <= sda_s;
                        end
                        if (scl_fall) begin
                            o_sda_oe_n <= 1'b1;
                            if (xmit && ack_received) begin
                                // leave the bus to the master for STOP
                                state <= S_IGN;
                            end else begin
                                o_scl_oe_n <= 1'b0;
                                state <= S_HOLD;
                            end
                        end
                    end
                    S_HOLD: begin
                        if (release_req) begin
                            release_req <= 1'b0;
                            bit_cnt <= 3'h0;
                            byte_done_flag <= 1'b0;
                            xmit <= transmit_select;
                            shifter <= data_reg;
                            if (transmit_select) begin
                                o_sda_oe_n <= data_reg[7];
                            end
                            state <= S_REL;
                        end
                    end
                    S_REL: begin
                        // one cycle of data setup before scl is let go
                        o_scl_oe_n <= 1'b1;
                        state <= S_DATA;
                    end
                    S_DATA: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 3'h1;
                            if (!xmit) begin
                                shifter <= shift_in;
                            end
                            if (last_bit) begin
                                byte_done_flag <= 1'b1;
                                o_irq_request <= 1'b1;
                                if (!xmit) begin
                                    data_reg <= shift_in;
                                end
                                ack_val <= xmit | ack_to_send;
                                state <= S_ACKD;
                            end
                        end else if (scl_fall && xmit) begin
                            shifter <= {shifter[6:0], 1'b0};
                            o_sda_oe_n <= shifter[6];
                        end
                    end
                    S_IGN: begin
                        o_scl_oe_n <= 1'b1;
                        o_sda_oe_n <= 1'b1;
                    end
                    default: begin
                        o_scl_oe_n <= 1'b1;
                        o_sda_oe_n <= 1'b1;
                    end
                endcase
            end
            // software writes follow the link so a store wins a collision
            if (wr_own) begin
                own_addr <= i_wdata[`TWS_OWN_MSB:`TWS_OWN_LSB];
            end
            if (wr_ctl) begin
                link_enable <= i_wdata[`TWS_CTL_EN];
                transmit_select <= i_wdata[`TWS_CTL_TX];
                ack_to_send <= i_wdata[`TWS_CTL_ACK];
            end
            if (wr_dat) begin
                data_reg <= i_wdata;
            end
            if (wr_dat | rd_dat) begin
                release_req <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

// ===== hdl/tws_sync.v
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// two-flop synchroniser, one per bit
// ----------------------------------------
module tws_sync #(
    parameter W = 2,
    parameter [W-1:0] RST = {W{1'b1}}
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [W-1:0] i_d,
    output wire [W-1:0] o_q
);
    genvar g;
    generate
        for (g = 0; g < W; g = g + 1) begin : g_bit
            reg meta;
            reg stable;
            // meta feeds only the second flop
            always @(posedge i_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    meta <= RST[g];
                    stable <= RST[g];
                end else begin
                    meta <= i_d[g];
                    stable <= meta;
                end
            end
            assign o_q[g] = stable;
        end
    endgenerate
endmodule

`default_nettype wire

// ===== test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic mclk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0;
    logic irq_en = 1'b0, full = 1'b0, ack;
    logic [7:0] addr = 8'h00, wdata = 8'h00, d;
    wire [7:0] rdata;
    wire scl_out, scl_oe_n, sda_out, sda_oe_n, m_scl_oe_n, m_sda_oe_n;
    wire irq_req, call;
    wire [11:0] vec;
    wire scl = m_scl_oe_n & (scl_oe_n | scl_out);
    wire sda = m_sda_oe_n & (sda_oe_n | sda_out);
    integer num_errors = 0, checked = 0, cycles = 0, i, calls = 0;
    tws_slave uut (.i_mclk(mclk), .i_rst_n(rst_n), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
        .i_scl(scl), .o_scl_out(scl_out), .o_scl_oe_n(scl_oe_n),
        .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
        .i_irq_enable(irq_en), .i_stack_full(full),
        .o_irq_request(irq_req), .o_call(call), .o_call_vector(vec));
    tws_master_model m (.i_scl(scl), .i_sda(sda),
        .o_scl_oe_n(m_scl_oe_n), .o_sda_oe_n(m_sda_oe_n));
    always #25 mclk = ~mclk;
    // count call pulses so a stuck or missing call shows up
    always @(posedge mclk) begin
        if (call === 1'b1) calls <= calls + 1;
    end
    // ----------------------------------------
    // access tasks and checks
    // ----------------------------------------
    task reg_wr(input [7:0] a, input [7:0] v);
        begin
            @(posedge mclk);
            addr <= a;
            wdata <= v;
            wr <= 1'b1;
            @(posedge mclk);
            wr <= 1'b0;
        end
    endtask
    task chk(input string w, input [7:0] e, input [7:0] g);
        begin
            checked = checked + 1;
            if (g !== e) begin
                num_errors = num_errors + 1;
                $display("CHECK FAILED %0s exp %h got %h", w, e, g);
            end
        end
    endtask
    // read data stand only in the cycle after the strobe
    task rd_chk(input [7:0] a, input [7:0] msk, input [7:0] e);
        begin
            @(posedge mclk);
            addr <= a;
            rd <= 1'b1;
            @(posedge mclk);
            rd <= 1'b0;
            #1 chk($sformatf("reg %h", a), e, rdata & msk);
        end
    endtask
    task test_done;
        begin
            $display("errors %0d checks %0d", num_errors, checked);
            if (num_errors == 0 && checked > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors = num_errors + 1;
            test_done;
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        for (i = 0; i < 5; i = i + 1) rd_chk(8'h20 + i[7:0], 8'hff, 8'h00);
        reg_wr(8'h20, 8'ha5);
        rd_chk(8'h20, 8'hff, 8'ha4);
        reg_wr(8'h22, 8'hff);
        rd_chk(8'h22, 8'hff, 8'h00);
        reg_wr(8'h21, 8'h7f);
        rd_chk(8'h21, 8'hff, 8'h18);
        reg_wr(8'h21, 8'h00);
        m.bus_start;
        m.put_byte(8'ha4, ack);
        chk("ack off", 8'h01, {7'h00, ack});
        rd_chk(8'h22, 8'hff, 8'h00);
        m.bus_stop;
        reg_wr(8'h21, 8'h80);
        m.bus_start;
        m.put_byte(8'h30, ack);
        chk("ack miss", 8'h01, {7'h00, ack});
        rd_chk(8'h22, 8'h60, 8'h20);
        m.bus_stop;
        rd_chk(8'h22, 8'h20, 8'h00);
        m.bus_start;
        m.put_byte(8'ha4, ack);
        chk("ack addr rx", 8'h00, {7'h00, ack});
        rd_chk(8'h22, 8'hff, 8'he0);
        @(posedge mclk);
        full <= 1'b1;
        irq_en <= 1'b1;
        repeat (4) @(posedge mclk);
        #1 chk("irq full", 8'h01, {7'h00, irq_req});
        full <= 1'b0;
        repeat (4) @(posedge mclk);
        #1 chk("irq call", 8'h00, {7'h00, irq_req});
        chk("call pulses", 8'h01, calls[7:0]);
        chk("call vector", 8'h10, vec[7:0]);
        chk("pin drive", 8'h00, {6'h00, scl_out, sda_out});
        irq_en <= 1'b0;
        rd_chk(8'h23, 8'h00, 8'h00);
        m.put_byte(8'h3c, ack);
        chk("ack rx", 8'h00, {7'h00, ack});
        chk("irq byte", 8'h01, {7'h00, irq_req});
        rd_chk(8'h23, 8'hff, 8'h3c);
        reg_wr(8'h21, 8'h88);
        rd_chk(8'h21, 8'hff, 8'h88);
        rd_chk(8'h22, 8'he4, 8'h20);
        m.put_byte(8'hc3, ack);
        chk("nack rx", 8'h01, {7'h00, ack});
        rd_chk(8'h23, 8'hff, 8'hc3);
        m.bus_stop;
        m.bus_start;
        m.put_byte(8'ha5, ack);
        chk("ack addr tx", 8'h00, {7'h00, ack});
        rd_chk(8'h22, 8'he4, 8'he4);
        reg_wr(8'h21, 8'h90);
        reg_wr(8'h23, 8'h96);
        m.get_byte(1'b0, d);
        chk("tx byte", 8'h96, d);
        rd_chk(8'h22, 8'h01, 8'h00);
        reg_wr(8'h23, 8'h5a);
        m.get_byte(1'b1, d);
        chk("tx last", 8'h5a, d);
        rd_chk(8'h22, 8'h01, 8'h01);
        chk("sda free", 8'h01, {7'h00, sda_oe_n});
        m.bus_stop;
        rd_chk(8'h22, 8'h20, 8'h00);
        test_done;
    end
endmodule
`default_nettype wire

// ===== test/tws_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module tws_master_model (
    input wire i_scl,
    input wire i_sda,
    output logic o_scl_oe_n,
    output logic o_sda_oe_n
);
    integer n;
    initial begin
        o_scl_oe_n = 1'b1;
        o_sda_oe_n = 1'b1;
    end
    // ----------------------------------------
    // bus master, 400 ns bit time
    // ----------------------------------------
    // the slave may stretch, so wait for the wire, but not forever
    task release_scl;
        begin
            o_scl_oe_n = 1'b1;
            for (n = 0; n < 400 && i_scl !== 1'b1; n = n + 1) #50;
            #200;
        end
    endtask
    task bus_start;
        begin
            o_sda_oe_n = 1'b1;
            release_scl;
            o_sda_oe_n = 1'b0;
            #200 o_scl_oe_n = 1'b0;
            #100;
        end
    endtask
    task bus_stop;
        begin
            o_sda_oe_n = 1'b0;
            #100 release_scl;
            o_sda_oe_n = 1'b1;
            #200;
        end
    endtask
    // b = 1 releases data, r is taken while the clock is high
    task bit_io(input b, output r);
        begin
            o_sda_oe_n = b;
            #100 release_scl;
            r = i_sda;
            o_scl_oe_n = 1'b0;
            #100;
        end
    endtask
    // extra low time after the ninth clock lets the slave grab the clock
    task put_byte(input [7:0] d, output ack);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_io(d[i], r);
            bit_io(1'b1, ack);
            #300;
        end
    endtask
    task get_byte(input a, output [7:0] d);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) bit_io(1'b1, d[i]);
            bit_io(a, r);
            #300;
        end
    endtask
endmodule
`default_nettype wire

// ===== test/tws_slave_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module tws_checker (
    input wire i_mclk,
    input wire i_rst_n,
    input wire [7:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire o_scl_out,
    input wire o_scl_oe_n,
    input wire o_sda_out,
    input wire o_sda_oe_n,
    input wire i_irq_enable,
    input wire i_stack_full,
    input wire o_irq_request,
    input wire o_call,
    input wire [11:0] o_call_vector
);
    reg en;
    wire acc_data = (i_wr || i_rd) && i_addr == 8'h23;
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    // ----------------------------------------
    // enable bit as last written
    // ----------------------------------------
    always @(posedge i_mclk or negedge i_rst_n)
        if (!i_rst_n) en <= 1'b0;
        else if (i_wr && i_addr == 8'h21) en <= i_wdata[7];
    pins_low_a: assert property (!o_scl_out && !o_sda_out)
        else $error("pin drive value not low");
    call_vec_a: assert property (o_call |-> o_call_vector == 12'h010)
        else $error("call vector wrong");
    call_cause_a: assert property (o_call |->
        $past(o_irq_request && i_irq_enable && !i_stack_full))
        else $error("call without enabled request");
    call_once_a: assert property (o_call |=> !o_call)
        else $error("call longer than one cycle");
    req_hold_a: assert property (
        o_irq_request && (!i_irq_enable || i_stack_full) |=> o_irq_request)
        else $error("request lost while blocked");
    ctl_zero_a: assert property (
        i_rd && i_addr == 8'h21 |=> (o_rdata & 8'h67) == 8'h00)
        else $error("control spare bits set");
    stat_zero_a: assert property (
        i_rd && i_addr == 8'h22 |=> (o_rdata & 8'h1a) == 8'h00)
        else $error("status spare bits set");
    own_bit0_a: assert property (i_rd && i_addr == 8'h20 |=> !o_rdata[0])
        else $error("own address bit0 set");
    ctl_back_a: assert property (i_wr && i_addr == 8'h21 ##2
        i_rd && i_addr == 8'h21 |=> o_rdata == ($past(i_wdata, 3) & 8'h98))
        else $error("control readback wrong");
    quiet_off_a: assert property (
        !en && !$past(en) |-> o_scl_oe_n && o_sda_oe_n)
        else $error("pin driven while disabled");
    stretch_end_a: assert property (acc_data |-> ##[1:4] o_scl_oe_n)
        else $error("clock still held after data access");
    cover property (o_call);
    cover property (!o_scl_oe_n);
    cover property (!o_sda_oe_n && en);
endmodule
bind tws_slave tws_checker u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .o_scl_out(o_scl_out), .o_scl_oe_n(o_scl_oe_n),
    .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
    .i_irq_enable(i_irq_enable), .i_stack_full(i_stack_full),
    .o_irq_request(o_irq_request), .o_call(o_call),
    .o_call_vector(o_call_vector));
`default_nettype wire
